/* hdl/aamc_pkg.sv */
// package: register map, field layout and timing constants for the measurement control block
package aamc_pkg;

  // ----------------------------------------------------------------------
  // special function register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TEMPERATURE_RESULT = 8'hd7;
  localparam logic [7:0] ADDR_MEASUREMENT_START  = 8'hd8;
  localparam logic [7:0] ADDR_BATTERY_RESULT     = 8'hdf;
  localparam logic [7:0] ADDR_SUPPLY_RESULT      = 8'hef;
  localparam logic [7:0] ADDR_CHANGE_DELTA       = 8'hf3;
  localparam logic [7:0] ADDR_BG_PERIOD          = 8'hf9;
  localparam logic [7:0] ADDR_LOW_BAT_THRESHOLD  = 8'hfa;

  // bit addresses of the start register, bit 0 sits at the register address
  localparam logic [7:0] BITADDR_START_BASE      = 8'hd8;
  localparam logic [7:0] BITADDR_START_TOP       = 8'hdf;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POS_SUPPLY_INTERVAL  = 4;
  localparam int POS_BATTERY_INTERVAL = 2;
  localparam int POS_TEMP_INTERVAL    = 0;
  localparam int POS_TEMP_DELTA       = 3;
  localparam int POS_SUPPLY_DELTA     = 0;
  localparam int POS_START_BATTERY    = 0;
  localparam int POS_START_TEMP       = 1;
  localparam int POS_START_SUPPLY     = 2;
  localparam int POS_CLOCK_LOSS_ACK   = 7;

  // ----------------------------------------------------------------------
  // reset value and change-delta codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_REG8     = 8'h00;
  localparam logic [2:0] DELTA_NONE   = 3'h0;
  localparam logic [2:0] DELTA_EVERY  = 3'h7;

  // ----------------------------------------------------------------------
  // time base: one minute at 50 MHz
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ          = 64'd50000000;
  localparam longint MINUTE_S        = 64'd60;
  localparam longint MINUTE_CYCLES   = CLK_HZ * MINUTE_S;
  localparam logic [3:0] MIN_16      = 4'hf;
  localparam logic [3:0] MIN_8       = 4'h7;
  localparam logic [3:0] MIN_4       = 4'h3;
  localparam logic [3:0] MIN_2       = 4'h1;

  // channel index
  localparam int CH_BATTERY = 0;
  localparam int CH_TEMP    = 1;
  localparam int CH_SUPPLY  = 2;
  localparam int NUM_CH     = 3;

  // request and answer towards one converter
  typedef struct packed {
    logic       req;
  } aamc_conv_req_t;

  typedef struct packed {
    logic       ack;
    logic       done;
    logic [7:0] data;
  } aamc_conv_rsp_t;

  // operating modes
  typedef enum logic [1:0] {
    AAMC_MODE_FULL,
    AAMC_MODE_BATTERY_ACTIVE,
    AAMC_MODE_SLEEP
  } aamc_mode_t;

endpackage : aamc_pkg

/* hdl/aamc_sync3.sv */
// module: three-stage synchroniser, change accepted once stages two and three agree
`timescale 1ns/100ps
module aamc_sync3 #(
  parameter int W = 1
) (
  // clocking
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;

  // per bit: stage one feeds only stage two; filter looks at two and three
  genvar b;
  for (b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (srst) begin
        s1_reg[b]  <= 1'b0;
        s2_reg[b]  <= 1'b0;
        s3_reg[b]  <= 1'b0;
        out_reg[b] <= 1'b0;
      end else if (ce) begin
        s1_reg[b] <= async_in[b];
        s2_reg[b] <= s1_reg[b];
        s3_reg[b] <= s2_reg[b];
        if (s2_reg[b] == s3_reg[b]) begin
          out_reg[b] <= s3_reg[b];
        end
      end
    end
  end

  assign sync_out = out_reg;

endmodule : aamc_sync3

/* hdl/aamc_top.sv */
// module: auxiliary temperature, battery and supply measurement control
`timescale 1ns/100ps
module aamc_top #(
  parameter longint MINUTE_CYCLES = aamc_pkg::MINUTE_CYCLES
) (
  // clocking
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // special function register port
  input  wire logic [7:0]              sfr_addr,
  input  wire logic                    sfr_wr,
  input  wire logic                    sfr_rd,
  input  wire logic [7:0]              sfr_wdata,
  input  wire logic                    bit_wr,
  input  wire logic [7:0]              bit_addr,
  input  wire logic                    bit_wdata,
  output logic      [7:0]              sfr_rdata,
  // power mode and clock fault
  input  wire aamc_pkg::aamc_mode_t    op_mode,
  input  wire logic                    pll_lock_reset,
  output logic                         clock_loss_fault,
  // converters, from the analog side
  output aamc_pkg::aamc_conv_req_t [2:0] conv_req,
  input  wire aamc_pkg::aamc_conv_rsp_t [2:0] conv_rsp,
  // events towards the core
  output logic                         temperature_irq,
  output logic                         supply_irq,
  output logic                         battery_irq,
  output logic                         low_battery_flag,
  input  wire logic                    low_battery_flag_clr
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] period_reg;
  logic [7:0] delta_reg;
  logic [7:0] threshold_reg;
  logic [2:0] start_reg;
  logic [7:0] result_reg [3];
  logic [7:0] ref_reg    [3];
  logic [2:0] bg_pend_reg;
  logic [2:0] oneshot_reg;
  logic [2:0] req_reg;
  logic [2:0] irq_reg;
  logic       fault_reg;
  logic       lowbat_reg;
  logic [7:0] rdata_reg;
  logic [31:0] tick_cnt_reg;
  logic [3:0]  minute_reg;

  // ----------------------------------------------------------------------
  // converter answers are from the analog domain: synchronise
  // ----------------------------------------------------------------------
  logic [2:0] ack_s;
  logic [2:0] done_s;
  logic [2:0] ack_d_reg;
  logic [2:0] done_d_reg;
  logic [5:0] raw_flags;
  logic [5:0] sync_flags;
  logic       lock_rst_s;

  // data is taken on done, after it has been stable for several cycles
  genvar c;
  for (c = 0; c < aamc_pkg::NUM_CH; c++) begin : g_raw
    assign raw_flags[c]     = conv_rsp[c].ack;
    assign raw_flags[c + 3] = conv_rsp[c].done;
  end

  aamc_sync3 #(.W(6)) u_sync_conv (
    .mclk     (mclk),
    .srst     (srst),
    .ce       (ce),
    .async_in (raw_flags),
    .sync_out (sync_flags)
  );

  aamc_sync3 #(.W(1)) u_sync_lock (
    .mclk     (mclk),
    .srst     (srst),
    .ce       (ce),
    .async_in (pll_lock_reset),
    .sync_out (lock_rst_s)
  );

  assign ack_s  = sync_flags[2:0];
  assign done_s = sync_flags[5:3];

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire wr_period = sfr_wr && (sfr_addr == aamc_pkg::ADDR_BG_PERIOD);
  wire wr_delta  = sfr_wr && (sfr_addr == aamc_pkg::ADDR_CHANGE_DELTA);
  wire wr_thresh = sfr_wr && (sfr_addr == aamc_pkg::ADDR_LOW_BAT_THRESHOLD);
  wire wr_start  = sfr_wr && (sfr_addr == aamc_pkg::ADDR_MEASUREMENT_START);
  wire bit_hit   = bit_wr && (bit_addr >= aamc_pkg::BITADDR_START_BASE)
                          && (bit_addr <= aamc_pkg::BITADDR_START_TOP);
  wire [2:0] bit_idx = bit_addr[2:0];

  // write data as seen by the start register, byte or single bit
  wire [7:0] start_wmask = wr_start ? 8'hff : (bit_hit ? (8'h01 << bit_idx) : 8'h00);
  wire [7:0] start_wval  = wr_start ? sfr_wdata : {8{bit_wdata}};
  wire [7:0] start_set   = start_wmask & start_wval;

  // low-power mode gating of background strobes
  wire bat_active  = (op_mode == aamc_pkg::AAMC_MODE_BATTERY_ACTIVE);
  wire sleep_mode  = (op_mode == aamc_pkg::AAMC_MODE_SLEEP);
  wire [2:0] bg_allow;
  assign bg_allow[aamc_pkg::CH_BATTERY] = !bat_active && !sleep_mode;
  assign bg_allow[aamc_pkg::CH_TEMP]    = !bat_active;
  assign bg_allow[aamc_pkg::CH_SUPPLY]  = 1'b1;

  // ----------------------------------------------------------------------
  // minute time base
  // ----------------------------------------------------------------------
  wire minute_tick = (tick_cnt_reg == 32'(MINUTE_CYCLES - 1));

  // free running so that every interval lines up on the same minute edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      tick_cnt_reg <= '0;
      minute_reg   <= 4'h0;
    end else if (ce) begin
      tick_cnt_reg <= minute_tick ? '0 : tick_cnt_reg + 32'h1;
      if (minute_tick) begin
        minute_reg <= minute_reg + 4'h1;
      end
    end
  end

  // interval selection per channel
  function automatic logic strobe_due(input logic [1:0] sel, input logic long16,
                                      input logic [3:0] minute);
    logic [3:0] mask;
    mask = 4'h0;
    unique case (sel)
      2'b00: mask = 4'h0;
      2'b01: mask = long16 ? aamc_pkg::MIN_16 : aamc_pkg::MIN_8;
      2'b10: mask = long16 ? aamc_pkg::MIN_4 : aamc_pkg::MIN_2;
      2'b11: mask = 4'h0;
    endcase
    strobe_due = (sel != 2'b00) && ((minute & mask) == 4'h0);
  endfunction : strobe_due

  wire [1:0] supply_bg_interval  = period_reg[aamc_pkg::POS_SUPPLY_INTERVAL +: 2];
  wire [1:0] battery_bg_interval = period_reg[aamc_pkg::POS_BATTERY_INTERVAL +: 2];
  wire [1:0] temp_bg_interval    = period_reg[aamc_pkg::POS_TEMP_INTERVAL +: 2];
  wire [2:0] temperature_delta_threshold = delta_reg[aamc_pkg::POS_TEMP_DELTA +: 3];
  wire [2:0] supply_delta_threshold      = delta_reg[aamc_pkg::POS_SUPPLY_DELTA +: 3];

  wire [2:0] bg_strobe;
  assign bg_strobe[aamc_pkg::CH_BATTERY] = minute_tick &&
    strobe_due(battery_bg_interval, 1'b1, minute_reg);
  assign bg_strobe[aamc_pkg::CH_TEMP]    = minute_tick &&
    strobe_due(temp_bg_interval, 1'b0, minute_reg);
  assign bg_strobe[aamc_pkg::CH_SUPPLY]  = minute_tick &&
    strobe_due(supply_bg_interval, 1'b0, minute_reg);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      period_reg    <= aamc_pkg::RST_REG8;
      delta_reg     <= aamc_pkg::RST_REG8;
      threshold_reg <= aamc_pkg::RST_REG8;
    end else if (ce) begin
      if (wr_period) period_reg    <= sfr_wdata;   // bits 7:6 stored as written
      if (wr_delta)  delta_reg     <= sfr_wdata;
      if (wr_thresh) threshold_reg <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // per-channel request, result and delta logic
  // ----------------------------------------------------------------------
  for (c = 0; c < aamc_pkg::NUM_CH; c++) begin : g_ch
    wire [2:0] dsel = (c == aamc_pkg::CH_TEMP)   ? temperature_delta_threshold :
                      (c == aamc_pkg::CH_SUPPLY) ? supply_delta_threshold : aamc_pkg::DELTA_NONE;
    wire [7:0] diff = (conv_rsp[c].data >= ref_reg[c]) ?
                      (conv_rsp[c].data - ref_reg[c]) : (ref_reg[c] - conv_rsp[c].data);
    wire done_rise  = done_s[c] && !done_d_reg[c];
    wire ack_rise   = ack_s[c] && !ack_d_reg[c];
    // strictly greater than the delta, 7 means every sample
    wire delta_hit  = (dsel == aamc_pkg::DELTA_EVERY) ||
                      ((dsel != aamc_pkg::DELTA_NONE) && (diff > {5'h00, dsel}));
    // battery always reports its result; low battery is judged separately
    wire fire       = done_rise && (oneshot_reg[c] || delta_hit ||
                      (c == aamc_pkg::CH_BATTERY));
    wire new_bg     = bg_strobe[c] && bg_allow[c];

    // one request in flight per converter; later strobes wait as pending
    always_ff @(posedge mclk) begin
      if (srst) begin
        start_reg[c]   <= 1'b0;
        bg_pend_reg[c] <= 1'b0;
        req_reg[c]     <= 1'b0;
        oneshot_reg[c] <= 1'b0;
        ack_d_reg[c]   <= 1'b0;
        done_d_reg[c]  <= 1'b0;
        irq_reg[c]     <= 1'b0;
        result_reg[c]  <= aamc_pkg::RST_REG8;
        ref_reg[c]     <= aamc_pkg::RST_REG8;
      end else if (ce) begin
        ack_d_reg[c]  <= ack_s[c];
        done_d_reg[c] <= done_s[c];
        irq_reg[c]    <= fire;
        // software may write 0 too; acceptance by the converter wins the clear
        if (ack_rise && req_reg[c] && oneshot_reg[c]) begin
          start_reg[c] <= 1'b0;
        end else if (start_wmask[c]) begin
          start_reg[c] <= start_wval[c];
        end
        if (new_bg) begin
          bg_pend_reg[c] <= 1'b1;
        end else if (!req_reg[c] && !start_reg[c] && !done_s[c]) begin
          bg_pend_reg[c] <= 1'b0;
        end
        if (!req_reg[c] && !done_s[c] && (start_reg[c] || bg_pend_reg[c])) begin
          req_reg[c]     <= 1'b1;
          oneshot_reg[c] <= start_reg[c];
        end else if (ack_rise) begin
          req_reg[c] <= 1'b0;
        end
        if (fire) begin
          result_reg[c] <= conv_rsp[c].data;
          ref_reg[c]    <= conv_rsp[c].data;
        end
        if (done_rise) begin
          oneshot_reg[c] <= 1'b0;
        end
      end
    end

    assign conv_req[c].req = req_reg[c];
  end

  // ----------------------------------------------------------------------
  // clock-loss fault and low battery flags
  // ----------------------------------------------------------------------
  wire ack_fault   = start_set[aamc_pkg::POS_CLOCK_LOSS_ACK];
  wire bat_done    = done_s[aamc_pkg::CH_BATTERY] && !done_d_reg[aamc_pkg::CH_BATTERY];
  wire bat_low     = bat_done && (conv_rsp[aamc_pkg::CH_BATTERY].data < threshold_reg);

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_reg  <= 1'b0;
      lowbat_reg <= 1'b0;
    end else if (ce) begin
      if (lock_rst_s) begin
        fault_reg <= 1'b1;
      end else if (ack_fault) begin
        fault_reg <= 1'b0;
      end
      if (bat_low) begin
        lowbat_reg <= 1'b1;
      end else if (low_battery_flag_clr) begin
        lowbat_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path, registered
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (sfr_addr)
      aamc_pkg::ADDR_TEMPERATURE_RESULT: rd_mux = result_reg[aamc_pkg::CH_TEMP];
      aamc_pkg::ADDR_MEASUREMENT_START:  rd_mux = {5'h00, start_reg};   // ack bit reads 0
      aamc_pkg::ADDR_BATTERY_RESULT:     rd_mux = result_reg[aamc_pkg::CH_BATTERY];
      aamc_pkg::ADDR_SUPPLY_RESULT:      rd_mux = result_reg[aamc_pkg::CH_SUPPLY];
      aamc_pkg::ADDR_CHANGE_DELTA:       rd_mux = delta_reg;
      aamc_pkg::ADDR_BG_PERIOD:          rd_mux = period_reg;
      aamc_pkg::ADDR_LOW_BAT_THRESHOLD:  rd_mux = threshold_reg;
      default:                           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= aamc_pkg::RST_REG8;
    end else if (ce && sfr_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign sfr_rdata        = rdata_reg;
  assign clock_loss_fault = fault_reg;
  assign low_battery_flag = lowbat_reg;
  assign temperature_irq  = irq_reg[aamc_pkg::CH_TEMP];
  assign supply_irq       = irq_reg[aamc_pkg::CH_SUPPLY];
  assign battery_irq      = irq_reg[aamc_pkg::CH_BATTERY];

endmodule : aamc_top

/* tb/aamc_conv_model.sv */
// model: three converters answering the four-phase request link
`timescale 1ns/100ps
module aamc_conv_model (
  // clocking
  input  wire logic                          mclk,
  // link
  input  wire aamc_pkg::aamc_conv_req_t [2:0] conv_req,
  output aamc_pkg::aamc_conv_rsp_t      [2:0] conv_rsp,
  // bench control
  input  wire logic [2:0][7:0]               value,
  input  wire logic [3:0]                    delay
);
  for (genvar c = 0; c < 3; c++) begin : g_ch
    // ack after req, done after req drops; data inverted once done falls so stale reads show
    initial begin
      conv_rsp[c] = '0;
      forever begin
        @(posedge mclk iff conv_req[c].req);
        repeat (delay) @(posedge mclk);
        #1 conv_rsp[c].ack = 1'b1;
        @(posedge mclk iff !conv_req[c].req);
        #1 conv_rsp[c].ack = 1'b0;
        conv_rsp[c].data = value[c];
        repeat (delay) @(posedge mclk);
        #1 conv_rsp[c].done = 1'b1;
        repeat (8) @(posedge mclk);
        #1 conv_rsp[c].done = 1'b0;
        conv_rsp[c].data = ~value[c];
      end
    end
  end
endmodule : aamc_conv_model

/* tb/aamc_top_chk.sv */
// checker: concurrent assertions on the measurement control ports
`timescale 1ns/100ps
module aamc_top_chk (
  // clocking
  input wire logic                          mclk,
  input wire logic                          srst,
  // register port
  input wire logic                          sfr_wr,
  input wire logic [7:0]                    sfr_addr,
  input wire logic [7:0]                    sfr_wdata,
  // fault and events
  input wire logic                          pll_lock_reset,
  input wire logic                          clock_loss_fault,
  input wire logic                          temperature_irq,
  input wire logic                          battery_irq,
  input wire logic                          low_battery_flag,
  input wire logic                          low_battery_flag_clr,
  // converter link
  input wire aamc_pkg::aamc_conv_req_t [2:0] conv_req,
  input wire aamc_pkg::aamc_conv_rsp_t [2:0] conv_rsp
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  logic [3:0] quiet_reg;

  // cycles since lock reset; the fault synchroniser must drain before a clear counts
  always_ff @(posedge mclk) begin
    if (srst || pll_lock_reset) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
  end

  // ----------------------------------------------------------------------
  // link and event relations
  // ----------------------------------------------------------------------
  irq_one_cycle_a: assert property (temperature_irq |=> !temperature_irq)
    else $error("temperature event longer than one cycle");
  req_held_a: assert property (conv_req[1].req && !conv_rsp[1].ack |=> conv_req[1].req)
    else $error("request dropped before acknowledge");
  req_release_a: assert property ($rose(conv_rsp[1].ack) |-> ##[2:7] !conv_req[1].req)
    else $error("request not released after acknowledge");
  req_not_busy_a: assert property (conv_req[2].req |-> !conv_rsp[2].done)
    else $error("request raised while converter busy");
  battery_event_a: assert property ($rose(conv_rsp[0].done) |-> ##[2:7] battery_irq)
    else $error("no battery event after conversion");
  flag_clear_a: assert property ($fell(low_battery_flag) |-> $past(low_battery_flag_clr))
    else $error("low battery flag fell without clear");
  fault_set_a: assert property (pll_lock_reset |-> ##[1:6] clock_loss_fault)
    else $error("clock loss fault not set");
  fault_ack_a: assert property (sfr_wr && sfr_addr == aamc_pkg::ADDR_MEASUREMENT_START
    && sfr_wdata[7] && quiet_reg == 4'hf |-> ##[1:2] !clock_loss_fault)
    else $error("clock loss fault not cleared");
endmodule : aamc_top_chk

/* tb/tb_aamc_top.sv */
// testbench: register sequences against the measurement control block
`timescale 1ns/100ps
module tb_aamc_top;
  logic                           mclk, srst, ce, sfr_wr, sfr_rd, bit_wr, bit_wdata;
  logic                           pll_lock_reset, low_battery_flag_clr, clock_loss_fault;
  logic                           temperature_irq, supply_irq, battery_irq, low_battery_flag;
  logic [7:0]                     sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  aamc_pkg::aamc_mode_t           op_mode;
  aamc_pkg::aamc_conv_req_t [2:0] conv_req;
  aamc_pkg::aamc_conv_rsp_t [2:0] conv_rsp;
  logic [2:0][7:0]                value;
  logic [3:0]                     delay;
  logic [2:0]                     req_q;
  int                             failures, compares, irq_cnt [3], req_cnt [3];
  // requests per 16 minutes for period codes 00..11: battery, then temperature and supply
  int                             exp_b [4] = '{0, 1, 4, 16}, exp_t [4] = '{0, 2, 8, 16};
  logic [7:0] res_a [3] = '{aamc_pkg::ADDR_BATTERY_RESULT, aamc_pkg::ADDR_TEMPERATURE_RESULT,
                            aamc_pkg::ADDR_SUPPLY_RESULT};

  aamc_top #(.MINUTE_CYCLES(64)) i_dut (.mclk(mclk), .srst(srst), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata), .sfr_rdata(sfr_rdata),
    .op_mode(op_mode), .pll_lock_reset(pll_lock_reset), .clock_loss_fault(clock_loss_fault),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .temperature_irq(temperature_irq),
    .supply_irq(supply_irq), .battery_irq(battery_irq), .low_battery_flag(low_battery_flag),
    .low_battery_flag_clr(low_battery_flag_clr));
  aamc_conv_model i_conv (.mclk(mclk), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .value(value), .delay(delay));

  // ----------------------------------------------------------------------
  // clock, event and request counters
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    irq_cnt[0] += int'(battery_irq === 1'b1);
    irq_cnt[1] += int'(temperature_irq === 1'b1);
    irq_cnt[2] += int'(supply_irq === 1'b1);
    for (int c = 0; c < 3; c++) req_cnt[c] += int'(conv_req[c].req === 1'b1 && !req_q[c]);
    for (int c = 0; c < 3; c++) req_q[c] = conv_req[c].req;
  end

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic span(input int n);
    repeat (n) @(negedge mclk);
  endtask : span
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic bw(input logic [7:0] a, input logic d);
    @(negedge mclk);
    bit_addr = a;
    bit_wdata = d;
    bit_wr = 1'b1;
    @(negedge mclk);
    bit_wr = 1'b0;
  endtask : bw
  // read data is sampled two edges after the strobe, covering either update edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    span(1);
    chk(sfr_rdata, exp);
  endtask : rd
  task automatic one_shot(input int c, input logic [7:0] v);
    int n0;
    n0 = irq_cnt[c];
    value[c] = v;
    bw(aamc_pkg::BITADDR_START_BASE + 8'(c), 1'b1);
    for (int i = 0; i < 300 && irq_cnt[c] == n0; i++) @(negedge mclk);
    chk(8'(irq_cnt[c] - n0), 8'h01);
    rd(res_a[c], v);
    rd(aamc_pkg::ADDR_MEASUREMENT_START, 8'h00);
  endtask : one_shot
  // request rises per channel over a window; a periodic strobe gives an exact count
  task automatic win(input int len, input int e0, input int e1, input int e2);
    int n [3];
    span(100);
    n = req_cnt;
    span(len);
    chk(8'(req_cnt[0] - n[0]), 8'(e0));
    chk(8'(req_cnt[1] - n[1]), 8'(e1));
    chk(8'(req_cnt[2] - n[2]), 8'(e2));
  endtask : win
  task automatic dtest(input int c, input int dpos, input int ppos);
    int n0;
    one_shot(c, 8'h40);
    wr(aamc_pkg::ADDR_CHANGE_DELTA, 8'h02 << dpos);
    wr(aamc_pkg::ADDR_BG_PERIOD, 8'h03 << ppos);
    n0 = irq_cnt[c];
    value[c] = 8'h42;
    span(300);
    chk(8'(irq_cnt[c] - n0), 8'h00);
    rd(res_a[c], 8'h40);
    value[c] = 8'h3d;
    span(300);
    chk(8'(irq_cnt[c] - n0), 8'h01);
    rd(res_a[c], 8'h3d);
    wr(aamc_pkg::ADDR_CHANGE_DELTA, 8'h07 << dpos);
    n0 = irq_cnt[c];
    span(300);
    chk(8'(irq_cnt[c] - n0 >= 3), 8'h01);
    wr(aamc_pkg::ADDR_CHANGE_DELTA, 8'h00);
    span(2); // a sample that landed with the write still used the old delta
    n0 = irq_cnt[c];
    span(300);
    chk(8'(irq_cnt[c] - n0), 8'h00);
    wr(aamc_pkg::ADDR_BG_PERIOD, 8'h00);
  endtask : dtest
  task automatic print_verdict;
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    print_verdict();
  end
  initial begin
    {srst, ce, sfr_wr, sfr_rd, bit_wr, bit_wdata, pll_lock_reset} = 7'h60;
    {sfr_addr, sfr_wdata, bit_addr, low_battery_flag_clr, req_q} = '0;
    op_mode = aamc_pkg::AAMC_MODE_FULL;
    value = '0;
    delay = 4'h6;
    span(16);
    srst = 1'b0;
    span(4);
    foreach (res_a[i]) rd(res_a[i], 8'h00);
    rd(8'h80, 8'h00);
    wr(8'h80, 8'h5a);
    rd(8'h80, 8'h00);
    wr(aamc_pkg::ADDR_MEASUREMENT_START, 8'h78);
    rd(aamc_pkg::ADDR_MEASUREMENT_START, 8'h00);
    wr(aamc_pkg::ADDR_LOW_BAT_THRESHOLD, 8'h50);
    rd(aamc_pkg::ADDR_LOW_BAT_THRESHOLD, 8'h50);
    one_shot(1, 8'h9c);
    delay = 4'h1;
    one_shot(2, 8'h37);
    one_shot(0, 8'h4f);
    chk(low_battery_flag, 8'h01);
    @(negedge mclk) low_battery_flag_clr = 1'b1;
    @(negedge mclk) low_battery_flag_clr = 1'b0;
    chk(low_battery_flag, 8'h00);
    one_shot(0, 8'h50);
    chk(low_battery_flag, 8'h00);
    dtest(1, aamc_pkg::POS_TEMP_DELTA, aamc_pkg::POS_TEMP_INTERVAL);
    dtest(2, aamc_pkg::POS_SUPPLY_DELTA, aamc_pkg::POS_SUPPLY_INTERVAL);
    for (int v = 0; v < 4; v++) begin
      wr(aamc_pkg::ADDR_BG_PERIOD, 8'(v * 21));
      rd(aamc_pkg::ADDR_BG_PERIOD, 8'(v * 21));
      win(1024, exp_b[v], exp_t[v], exp_t[v]);
    end
    op_mode = aamc_pkg::AAMC_MODE_BATTERY_ACTIVE;
    win(256, 0, 0, 4);
    op_mode = aamc_pkg::AAMC_MODE_SLEEP;
    win(256, 0, 4, 4);
    wr(aamc_pkg::ADDR_BG_PERIOD, 8'h00);
    @(negedge mclk) pll_lock_reset = 1'b1;
    span(2);
    pll_lock_reset = 1'b0;
    span(8);
    chk(clock_loss_fault, 8'h01);
    span(16);
    wr(aamc_pkg::ADDR_MEASUREMENT_START, 8'h80);
    span(2);
    chk(clock_loss_fault, 8'h00);
    @(negedge mclk) pll_lock_reset = 1'b1;
    span(2); // the input filter drops a one-cycle pulse
    pll_lock_reset = 1'b0;
    span(24);
    chk(clock_loss_fault, 8'h01);
    bw(aamc_pkg::BITADDR_START_TOP, 1'b1);
    span(2);
    chk(clock_loss_fault, 8'h00);
    rd(aamc_pkg::ADDR_MEASUREMENT_START, 8'h00);
    print_verdict();
  end
endmodule : tb_aamc_top

bind aamc_top aamc_top_chk i_chk (.mclk(mclk), .srst(srst), .sfr_wr(sfr_wr),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .pll_lock_reset(pll_lock_reset),
  .clock_loss_fault(clock_loss_fault), .temperature_irq(temperature_irq),
  .battery_irq(battery_irq), .low_battery_flag(low_battery_flag),
  .low_battery_flag_clr(low_battery_flag_clr), .conv_req(conv_req), .conv_rsp(conv_rsp));
